// ### design/adcct_top.sv
`timescale 1ns/1ps
// Operation
// [R1] basic clock divided by selected divider code
// [R2] sample window length from sample code
// [R3] conversion takes sample+40 bc+2 cpu exactly
// [R4] calibration after reset, 3328 basic clocks
// [R5] divider code resets to divide by four
// [R6] conversions allowed during calibration, extending it
// [R7] result clamps to 000 or 3ff
// [R8] software keeps basic clock 0.5 to 6.25 MHz
// [R9] software programs divider soon after reset
// [R10] input captured only inside sample window
// [R11] busy from sampling to load, then done
module adcct_top (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [1:0] conversion_clock_divider_select,
    input wire logic [1:0] sample_time_select,
    input wire logic start,
    input wire logic [10:0] analog_level,
    output logic sample_en,
    output logic busy,
    output logic done,
    output logic cal_active,
    output logic [9:0] result
);
    adcct_pkg::adcct_state_t state_q;
    logic [1:0] div_q;
    logic [1:0] sts_q;
    logic [5:0] bc_cnt_q;
    logic [6:0] smp_cnt_q;
    logic lcnt_q;
    logic [11:0] cal_cnt_q;
    logic cal_q;
    logic [10:0] held_q;
    logic [9:0] result_q;
    logic [9:0] result_d;
    logic done_q;
    logic bc_tick;
    logic go;
    logic is_idle;
    logic smp_end;
    logic conv_end;
    logic load_end;
    logic cal_tick;

    assign is_idle = (state_q == adcct_pkg::ADCCT_IDLE);
    assign go = is_idle && start;

    // last tick of the sample window and of the conversion periods
    assign smp_end = bc_tick && (smp_cnt_q == adcct_pkg::sts_last(sts_q)); // [R2]
    assign conv_end = bc_tick && (bc_cnt_q == 6'(adcct_pkg::CONV_BC - 1)); // [R3]

    // final cpu cycle of the result load
    assign load_end = (state_q == adcct_pkg::ADCCT_LOAD)
        && (lcnt_q == 1'(adcct_pkg::LOAD_CPU - 1)); // [R3]

    // calibration counts basic clocks only while no conversion runs
    assign cal_tick = cal_q && is_idle && bc_tick; // [R6]

    // a take restarts the divider so every conversion has the same length
    adcct_bcgen u_bcgen (
        .mclk(mclk),
        .rst_n(rst_n),
        .div_sel(div_q),
        .sync(go),
        .bc_tick(bc_tick)
    );

    // settings are latched at idle so a conversion keeps fixed timing
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            div_q <= adcct_pkg::DIV_RST; // [R5]
        else if (is_idle)
            div_q <= conversion_clock_divider_select; // [R1] [R8] [R9]
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            sts_q <= adcct_pkg::STS_RST;
        else if (is_idle)
            sts_q <= sample_time_select; // [R2]
    end

    // conversion sequence: sample, convert, load, back to idle
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            state_q <= adcct_pkg::ADCCT_IDLE;
        else
        begin
            unique case (state_q)
                adcct_pkg::ADCCT_IDLE:
                begin
                    if (start)
                        state_q <= adcct_pkg::ADCCT_SAMPLE; // [R6]
                end
                adcct_pkg::ADCCT_SAMPLE:
                begin
                    if (smp_end)
                        state_q <= adcct_pkg::ADCCT_CONVERT; // [R2]
                end
                adcct_pkg::ADCCT_CONVERT:
                begin
                    if (conv_end)
                        state_q <= adcct_pkg::ADCCT_LOAD; // [R3]
                end
                adcct_pkg::ADCCT_LOAD:
                begin
                    if (load_end)
                        state_q <= adcct_pkg::ADCCT_IDLE; // [R3]
                end
                default:
                begin
                    state_q <= adcct_pkg::ADCCT_IDLE;
                end
            endcase
        end
    end

    // basic clock periods spent in the sample window
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            smp_cnt_q <= 7'h00;
        else if (state_q != adcct_pkg::ADCCT_SAMPLE)
            smp_cnt_q <= 7'h00;
        else if (bc_tick)
            smp_cnt_q <= smp_cnt_q + 7'h01; // [R2]
    end

    // basic clock periods spent converting
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            bc_cnt_q <= 6'h00;
        else if (state_q != adcct_pkg::ADCCT_CONVERT)
            bc_cnt_q <= 6'h00;
        else if (bc_tick)
            bc_cnt_q <= bc_cnt_q + 6'h01; // [R3]
    end

    // cpu cycles spent loading the result
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            lcnt_q <= 1'b0;
        else if (state_q != adcct_pkg::ADCCT_LOAD)
            lcnt_q <= 1'b0;
        else
            lcnt_q <= 1'b1; // [R3]
    end

    // track input during sampling only; frozen afterwards
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            held_q <= 11'h000;
        else if (state_q == adcct_pkg::ADCCT_SAMPLE)
            held_q <= analog_level; // [R10]
    end

    // bit 10 of the input code marks a level above the reference
    always_comb
    begin
        result_d = held_q[9:0];
        if (held_q[10])
            result_d = adcct_pkg::RES_MAX; // [R7]
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            result_q <= adcct_pkg::RES_MIN;
        else if (load_end)
            result_q <= result_d; // [R3]
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            done_q <= 1'b0;
        else
            done_q <= load_end; // [R11]
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            cal_cnt_q <= 12'h000;
        else if (cal_tick)
            cal_cnt_q <= cal_cnt_q + 12'h001; // [R6]
    end

    // ends once the full count has passed in idle
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            cal_q <= 1'b1; // [R4]
        else if (cal_tick && cal_cnt_q == 12'(adcct_pkg::CAL_BC - 1))
            cal_q <= 1'b0; // [R4]
    end

    // status pins decoded from the sequence state
    always_comb
    begin
        sample_en = 1'b0;
        busy = 1'b1;
        unique case (state_q)
            adcct_pkg::ADCCT_IDLE:
                busy = 1'b0;
            adcct_pkg::ADCCT_SAMPLE:
                sample_en = 1'b1; // [R10]
            adcct_pkg::ADCCT_CONVERT,
            adcct_pkg::ADCCT_LOAD:
                busy = 1'b1; // [R11]
            default:
                busy = 1'b1;
        endcase
    end

    assign done = done_q;
    assign cal_active = cal_q;
    assign result = result_q;
endmodule : adcct_top

// ### design/adcct_pkg.sv
package adcct_pkg;
    // divider codes: 00 /4, 01 /2, 10 /16, 11 /8
    localparam logic [1:0] DIV_RST = 2'h0;
    localparam logic [1:0] STS_RST = 2'h0;
    localparam int unsigned CONV_BC = 40;
    localparam int unsigned LOAD_CPU = 2;
    localparam int unsigned CAL_BC = 3328;
    localparam logic [9:0] RES_MIN = 10'h000;
    localparam logic [9:0] RES_MAX = 10'h3ff;
    localparam int unsigned MCLK_MHZ = 40;
    localparam int unsigned MCLK_NS = 25;
    typedef enum logic [2:0] {
        ADCCT_IDLE = 3'b000,
        ADCCT_SAMPLE = 3'b001,
        ADCCT_CONVERT = 3'b010,
        ADCCT_LOAD = 3'b011
    } adcct_state_t;

    // divide ratio minus one for a divider code
    function automatic logic [3:0] div_last(input logic [1:0] code);
        logic [3:0] r;
        r = 4'h3;
        unique case (code)
            2'h0: r = 4'h3;
            2'h1: r = 4'h1;
            2'h2: r = 4'hf;
            2'h3: r = 4'h7;
        endcase
        return r;
    endfunction : div_last

    // sample window in basic clock periods minus one
    function automatic logic [6:0] sts_last(input logic [1:0] code);
        logic [6:0] r;
        r = 7'h07;
        unique case (code)
            2'h0: r = 7'h07;
            2'h1: r = 7'h0f;
            2'h2: r = 7'h1f;
            2'h3: r = 7'h3f;
        endcase
        return r;
    endfunction : sts_last
endpackage : adcct_pkg

// ### design/adcct_bcgen.sv
`timescale 1ns/1ps
// basic clock tick generator from the cpu clock
module adcct_bcgen (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [1:0] div_sel,
    input wire logic sync,
    output logic bc_tick
);
    logic [3:0] cnt_q;

    // sync restarts the period so a conversion starts on a whole period
    always_ff @(posedge mclk)
    begin
        if (!rst_n || sync || cnt_q >= adcct_pkg::div_last(div_sel))
            cnt_q <= 4'h0;
        else
            cnt_q <= cnt_q + 4'h1;
    end

    assign bc_tick = (cnt_q == adcct_pkg::div_last(div_sel)) && !sync; // [R1]
endmodule : adcct_bcgen

// ### tb/adcct_checker.sv
`timescale 1ns/1ps
module adcct_checker (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [1:0] conversion_clock_divider_select,
    input wire logic [1:0] sample_time_select,
    input wire logic start,
    input wire logic sample_en,
    input wire logic busy,
    input wire logic done,
    input wire logic cal_active,
    input wire logic [9:0] result
);
    logic [11:0] n_q;
    logic [11:0] e_q;
    logic [11:0] s_q;
    logic [2:0] x;
    // log2 of the divide ratio
    assign x = (conversion_clock_divider_select[1] ? 3'h2 : 3'h0)
        + (conversion_clock_divider_select[0] ? 3'h1 : 3'h2);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge mclk)
    begin
        n_q <= busy ? n_q + 12'h1 : 12'h0;
    end
    always_ff @(posedge mclk)
    begin
        if (!busy)
        begin
            s_q <= (12'h8 << sample_time_select) << x;
            e_q <= (((12'h8 << sample_time_select) + 12'h28) << x) + 12'h2;
        end
    end
    AST_TAKE: assert property (start && !busy |=> busy && sample_en)
        else $error("start not taken");
    AST_SAMPLE_LEN: assert property ($fell(sample_en) |-> n_q == s_q)
        else $error("sample window length wrong");
    AST_CONV_LEN: assert property ($fell(busy) |-> n_q == e_q)
        else $error("conversion length wrong");
    AST_DONE: assert property ($fell(busy) |-> done)
        else $error("no done after busy");
    AST_DONE_PULSE: assert property (done |=> !done)
        else $error("done longer than one cycle");
    AST_WINDOW: assert property (sample_en |-> busy)
        else $error("sampling outside conversion");
    AST_RESULT: assert property ($changed(result) |-> $past(busy))
        else $error("result changed while idle");
    AST_CAL: assert property (!$rose(cal_active))
        else $error("calibration restarted");
endmodule : adcct_checker

// ### tb/adcct_source.sv
`timescale 1ns/1ps
module adcct_source (
    input wire logic mclk,
    input wire logic sample_en,
    input wire logic [10:0] level,
    output logic [10:0] analog_level
);
    // input moves away once the window closes
    always_ff @(negedge mclk)
    begin
        analog_level <= sample_en ? level : ~level;
    end
endmodule : adcct_source

// ### tb/adcct_top_bench.sv
`timescale 1ns/1ps
module adcct_top_bench;
    logic mclk = 0, rst_n = 0, start = 0, sample_en, busy, done, cal_active;
    logic [1:0] div = 0, sts = 0;
    logic [10:0] lvl = 0, analog_level;
    logic [9:0] result;
    int bad_count = 0, comparisons = 0, n, cyc = 0, idle = 0;
    // divider, sample code, level, then cycles busy and result expected
    logic [40:0] rows [4] = '{
        {2'h0, 2'h3, 11'h400, 16'h01a2, 10'h3ff},
        {2'h1, 2'h2, 11'h7ff, 16'h0092, 10'h3ff},
        {2'h2, 2'h1, 11'h000, 16'h0382, 10'h000},
        {2'h3, 2'h0, 11'h155, 16'h0182, 10'h155}};
    adcct_top u_dut (.mclk, .rst_n, .conversion_clock_divider_select(div),
        .sample_time_select(sts), .start, .analog_level, .sample_en, .busy,
        .done, .cal_active, .result);
    adcct_source u_src (.mclk, .sample_en, .level(lvl), .analog_level);
    initial forever #12.5 mclk = ~mclk;
    always @(negedge mclk)
        idle = !rst_n ? 0 : idle + int'(cal_active === 1'b1 && busy === 1'b0);
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            bad_count++;
            test_done();
        end
    end
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task conv(input logic [40:0] r);
        {div, sts, lvl} = r[40:26];
        start = 1;
        @(negedge mclk);
        start = 0;
        div = ~r[40:39];
        sts = ~r[38:37];
        n = 0;
        while (busy === 1'b1 && n < 2000)
        begin
            n++;
            @(negedge mclk);
        end
        chk("len", r[25:10], 16'(n));
        chk("done", 16'h1, 16'(done));
        chk("result", 16'(r[9:0]), 16'(result));
    endtask : conv
    task test_done;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (16) @(negedge mclk);
        rst_n = 1;
        for (int i = 0; i < 4; i++) conv(rows[i]);
        chk("cal", 16'h1, 16'(cal_active));
        $display("table test done");
        rst_n = 0;
        repeat (16) @(negedge mclk);
        chk("rst", 16'h1, 16'({result, busy, done, cal_active}));
        $display("reset test done");
        div = 0;
        rst_n = 1;
        repeat (1000) @(negedge mclk);
        conv({2'h0, 2'h0, 11'h155, 16'h00c2, 10'h155});
        div = 2'h3;
        while (cal_active === 1'b1 && cyc < 39000) @(negedge mclk);
        chk("cal", 16'h1, 16'(idle >= 25616 && idle <= 25648));
        $display("calibration test done");
        test_done();
    end
endmodule : adcct_top_bench
bind adcct_top adcct_checker u_chk (.mclk, .rst_n, .conversion_clock_divider_select,
    .sample_time_select, .start, .sample_en, .busy, .done, .cal_active, .result);
